/* File: hdl/ibe_cond_eval.sv */
// branch condition evaluator for the relative branches
// assumes the tested bit was already captured by the executor
`timescale 1ns/1ps
`default_nettype none
module ibe_cond_eval (
  input  wire ibe_pkg::ibe_op_e op,
  input  wire logic             bit_val,
  input  wire logic             carry,
  input  wire logic [7:0]       acc,
  output logic                  taken
);
  always_comb begin
    unique case (op)
      ibe_pkg::OP_BSET,
      ibe_pkg::OP_BTCL: taken = bit_val;
      ibe_pkg::OP_BCLR: taken = !bit_val;
      ibe_pkg::OP_CY:   taken = carry;
      ibe_pkg::OP_NCY:  taken = !carry;
      ibe_pkg::OP_ANZ:  taken = |acc;
      ibe_pkg::OP_AZ:   taken = ~|acc;
      default:         taken = 1'b0;
    endcase
  end
endmodule : ibe_cond_eval
`default_nettype wire

/* File: hdl/ibe_exec.sv */
// increment and branch executor: runs one instruction at a time on its own pc, sp and data pointer
// assumes a data memory whose read data answers the registered address in the same mclk
//
// Functional notes
// - byte increment done in one machine cycle
// - data pointer increments with carry, no flags
// - bit-set branch: pc+3, branch if one
// - bit-clear branch: pc+3, branch if zero
// - test-and-clear branch always leaves bit zero
// - test-and-clear reads port bits from latch
// - carry branch: pc+2, branch if carry
// - no-carry branch: pc+2, carry untouched
// - branch when accumulator nonzero, pc+2
// - branch when accumulator zero, pc+2
// - indirect jump to accumulator plus pointer
// - long call pushes pc+3, low first
// - long call loads pc from bytes two, three
// - byte increment wraps, no flags change
// - byte increment reads ports from latch
`timescale 1ns/1ps
`default_nettype none
module ibe_exec (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        exec_valid,
  input  wire logic [7:0]  exec_opcode,
  input  wire logic [7:0]  exec_byte2,
  input  wire logic [7:0]  exec_byte3,
  output logic             exec_ready,
  output logic             exec_done,
  input  wire logic [7:0]  acc,
  input  wire logic        carry,
  input  wire logic [1:0]  bank_sel,
  output logic [7:0]       mem_addr,
  input  wire logic [7:0]  mem_rd_data,
  output logic [7:0]       mem_wr_data,
  output logic             mem_wr_en,
  output logic             mem_latch_sel,
  input  wire logic        state_wr_en,
  input  wire logic [15:0] state_pc,
  input  wire logic [7:0]  state_stk,
  input  wire logic [15:0] state_dp,
  output logic [15:0]      pc,
  output logic [7:0]       stack_pointer,
  output logic [15:0]      data_pointer
);

  ibe_pkg::ibe_state_e state_q, state_d;
  ibe_pkg::ibe_op_e    op_q, op_d;
  logic [1:0]  phase_q, phase_d;
  logic        mcyc_q, mcyc_d;
  logic [7:0]  b2_q, b2_d;
  logic [7:0]  b3_q, b3_d;
  logic        bitval_q, bitval_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0]  stk_q, stk_d;
  logic [15:0] dp_q, dp_d;
  logic [7:0]  addr_q, addr_d;
  logic [7:0]  wdata_q, wdata_d;
  logic        we_q, we_d;
  logic        latch_q, latch_d;
  logic        taken;
  logic [15:0] target;
  logic [7:0]  disp;
  logic        accept;
  logic        finish;
  ibe_pkg::ibe_op_e new_op;

  // the machine cycle tick is the last phase of a free-running divider
  assign exec_ready = (state_q == ibe_pkg::ST_IDLE) && (phase_q == ibe_pkg::PHASE_LAST) && !state_wr_en;
  assign accept     = exec_ready && exec_valid;
  assign finish     = (state_q == ibe_pkg::ST_EXEC) && (phase_q == ibe_pkg::PHASE_LAST)
                      && (mcyc_q == ibe_pkg::ibe_long(op_q));
  assign exec_done  = finish;
  assign new_op     = ibe_pkg::ibe_decode(exec_opcode);
  assign disp       = (op_q inside {ibe_pkg::OP_BSET, ibe_pkg::OP_BCLR, ibe_pkg::OP_BTCL}) ? b3_q : b2_q;

  assign mem_addr      = addr_q;
  assign mem_wr_data   = wdata_q;
  assign mem_wr_en     = we_q;
  assign mem_latch_sel = latch_q;
  assign pc            = pc_q;
  assign stack_pointer = stk_q;
  assign data_pointer  = dp_q;

  ibe_cond_eval u_cond (
    .op      (op_q),
    .bit_val (bitval_q),
    .carry   (carry),
    .acc     (acc),
    .taken   (taken)
  );

  // with taken low this is also the return address of the long call
  ibe_rel_target u_target (
    .pc      (pc_q),
    .len     (ibe_pkg::ibe_len(op_q)),
    .taken   (taken),
    .disp    (disp),
    .target  (target)
  );

  always_comb begin
    state_d  = state_q;
    op_d     = op_q;
    phase_d  = 2'(phase_q + 2'h1);
    mcyc_d   = mcyc_q;
    b2_d     = b2_q;
    b3_d     = b3_q;
    bitval_d = bitval_q;
    pc_d     = pc_q;
    stk_d    = stk_q;
    dp_d     = dp_q;
    addr_d   = addr_q;
    wdata_d  = wdata_q;
    we_d     = 1'b0;
    latch_d  = latch_q;
    if (state_q == ibe_pkg::ST_IDLE) begin
      if (state_wr_en) begin
        pc_d   = state_pc;
        stk_d  = state_stk;
        dp_d   = state_dp;
      end else if (accept) begin
        state_d = ibe_pkg::ST_EXEC;
        op_d    = new_op;
        mcyc_d  = 1'b0;
        b2_d    = exec_byte2;
        b3_d    = exec_byte3;
        latch_d = 1'b0;
        unique case (new_op)
          ibe_pkg::OP_INC_DIR: begin
            addr_d  = exec_byte2;
            latch_d = 1'b1;
          end
          ibe_pkg::OP_INC_IND: begin
            addr_d = {3'h0, bank_sel, 2'h0, exec_opcode[0]};
          end
          ibe_pkg::OP_BSET, ibe_pkg::OP_BCLR: begin
            addr_d = ibe_pkg::ibe_bit_byte(exec_byte2);
          end
          ibe_pkg::OP_BTCL: begin
            addr_d  = ibe_pkg::ibe_bit_byte(exec_byte2);
            latch_d = 1'b1;
          end
          default: begin
            addr_d = addr_q;
          end
        endcase
      end
    end else begin
      if (!mcyc_q) begin
        unique case (phase_q)
          ibe_pkg::PHASE_FIRST: begin
            unique case (op_q)
              ibe_pkg::OP_INC_DIR: begin
                wdata_d = 8'(mem_rd_data + ibe_pkg::BYTE_ONE);
                we_d    = 1'b1;
              end
              ibe_pkg::OP_INC_IND: begin
                addr_d  = mem_rd_data;
                latch_d = 1'b1;
              end
              ibe_pkg::OP_BSET, ibe_pkg::OP_BCLR: begin
                bitval_d = mem_rd_data[b2_q[2:0]];
              end
              ibe_pkg::OP_BTCL: begin
                bitval_d = mem_rd_data[b2_q[2:0]];
                wdata_d  = mem_rd_data & ~(ibe_pkg::BYTE_ONE << b2_q[2:0]);
                we_d     = 1'b1;
              end
              ibe_pkg::OP_CALL: begin
                stk_d   = 8'(stk_q + ibe_pkg::BYTE_ONE);
                addr_d  = 8'(stk_q + ibe_pkg::BYTE_ONE);
                wdata_d = target[7:0];
                we_d    = 1'b1;
              end
              default: begin
                we_d = 1'b0;
              end
            endcase
          end
          2'h1: begin
            if (op_q == ibe_pkg::OP_INC_IND) begin
              wdata_d = 8'(mem_rd_data + ibe_pkg::BYTE_ONE);
              we_d    = 1'b1;
            end else if (op_q == ibe_pkg::OP_CALL) begin
              stk_d   = 8'(stk_q + ibe_pkg::BYTE_ONE);
              addr_d  = 8'(stk_q + ibe_pkg::BYTE_ONE);
              wdata_d = target[15:8];
              we_d    = 1'b1;
            end
          end
          default: begin
            latch_d = latch_q;
          end
        endcase
      end
      if (phase_q == ibe_pkg::PHASE_LAST) begin
        mcyc_d = 1'b1;
      end
      if (finish) begin
        state_d = ibe_pkg::ST_IDLE;
        mcyc_d  = 1'b0;
        latch_d = 1'b0;
        unique case (op_q)
          ibe_pkg::OP_NONE: begin
            pc_d = pc_q;
          end
          ibe_pkg::OP_INC_DP: begin
            dp_d = 16'(dp_q + ibe_pkg::WORD_ONE);
            pc_d = target;
          end
          ibe_pkg::OP_JMP_IND: begin
            pc_d = 16'({8'h00, acc} + dp_q);
          end
          ibe_pkg::OP_CALL: begin
            pc_d = {b2_q, b3_q};
          end
          default: begin
            pc_d = target;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q  <= ibe_pkg::ST_IDLE;
      op_q     <= ibe_pkg::OP_NONE;
      phase_q  <= ibe_pkg::PHASE_FIRST;
      mcyc_q   <= 1'b0;
      b2_q     <= 8'h00;
      b3_q     <= 8'h00;
      bitval_q <= 1'b0;
      pc_q     <= ibe_pkg::PC_RST;
      stk_q    <= ibe_pkg::STK_RST;
      dp_q     <= ibe_pkg::DP_RST;
      addr_q   <= 8'h00;
      wdata_q  <= 8'h00;
      we_q     <= 1'b0;
      latch_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      op_q     <= op_d;
      phase_q  <= phase_d;
      mcyc_q   <= mcyc_d;
      b2_q     <= b2_d;
      b3_q     <= b3_d;
      bitval_q <= bitval_d;
      pc_q     <= pc_d;
      stk_q    <= stk_d;
      dp_q     <= dp_d;
      addr_q   <= addr_d;
      wdata_q  <= wdata_d;
      we_q     <= we_d;
      latch_q  <= latch_d;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_inc_byte;
    we_q && (op_q inside {ibe_pkg::OP_INC_DIR, ibe_pkg::OP_INC_IND})
      |-> (wdata_q == 8'($past(mem_rd_data) + 8'h01)) && latch_q;
  endproperty
  a_inc_byte: assert property (p_inc_byte) else $error("byte increment wrote wrong value");

  property p_one_cycle;
    accept && (new_op inside {ibe_pkg::OP_INC_DIR, ibe_pkg::OP_INC_IND}) |-> ##4 exec_done;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("byte increment not done in one machine cycle");

  property p_two_cycle;
    accept && ibe_pkg::ibe_long(new_op) |-> !exec_done [*8] ##1 exec_done;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("two-cycle operation timing wrong");

  property p_data_pointer;
    exec_done && op_q == ibe_pkg::OP_INC_DP |=> dp_q == 16'($past(dp_q) + 16'h0001);
  endproperty
  a_data_pointer: assert property (p_data_pointer) else $error("data pointer increment wrong");

  property p_bit_kept;
    (op_q inside {ibe_pkg::OP_BSET, ibe_pkg::OP_BCLR, ibe_pkg::OP_CY, ibe_pkg::OP_NCY,
                  ibe_pkg::OP_AZ, ibe_pkg::OP_ANZ, ibe_pkg::OP_JMP_IND, ibe_pkg::OP_INC_DP}) |-> !we_q;
  endproperty
  a_bit_kept: assert property (p_bit_kept) else $error("non-writing operation wrote memory");

  property p_jbc_clear;
    we_q && op_q == ibe_pkg::OP_BTCL |-> !wdata_q[b2_q[2:0]] && latch_q;
  endproperty
  a_jbc_clear: assert property (p_jbc_clear) else $error("test-and-clear left bit set");

  property p_carry_branch;
    exec_done && op_q == ibe_pkg::OP_CY
      |=> pc_q == 16'($past(pc_q) + 16'h0002 + ($past(carry) ? ibe_pkg::ibe_sext($past(b2_q)) : 16'h0000));
  endproperty
  a_carry_branch: assert property (p_carry_branch) else $error("carry branch target wrong");

  property p_zero_branch;
    exec_done && op_q == ibe_pkg::OP_AZ
      |=> pc_q == 16'($past(pc_q) + 16'h0002 + (($past(acc) == 8'h00) ? ibe_pkg::ibe_sext($past(b2_q)) : 16'h0000));
  endproperty
  a_zero_branch: assert property (p_zero_branch) else $error("zero branch target wrong");

  property p_jmp_ind;
    exec_done && op_q == ibe_pkg::OP_JMP_IND |=> pc_q == 16'({8'h00, $past(acc)} + $past(dp_q)) && $stable(dp_q);
  endproperty
  a_jmp_ind: assert property (p_jmp_ind) else $error("indirect jump target wrong");

  property p_call_push;
    accept && new_op == ibe_pkg::OP_CALL
      |-> ##2 (we_q && addr_q == 8'($past(stk_q, 2) + 8'h01) && wdata_q == 8'($past(pc_q, 2) + 16'h0003))
          ##1 (we_q && addr_q == 8'($past(stk_q, 3) + 8'h02)) ##6 (pc_q == {$past(b2_q), $past(b3_q, 6)});
  endproperty
  a_call_push: assert property (p_call_push) else $error("long call push or load wrong");

  property p_ind_ptr;
    accept && new_op == ibe_pkg::OP_INC_IND |=> addr_q == {3'h0, $past(bank_sel), 2'h0, $past(exec_opcode[0])};
  endproperty
  a_ind_ptr: assert property (p_ind_ptr) else $error("pointer register select wrong");

endmodule : ibe_exec
`default_nettype wire

/* File: hdl/ibe_pkg.sv */
// constants, operation codes and helper functions for the increment and branch executor
// assumes one mclk domain; a machine cycle is a fixed number of mclk phases
package ibe_pkg;

  // opcode encodings handled by this executor
  localparam logic [7:0] OPC_INC_DIR  = 8'h05;
  localparam logic [7:0] OPC_INC_IND0 = 8'h06;
  localparam logic [7:0] OPC_INC_IND1 = 8'h07;
  localparam logic [7:0] OPC_INC_DP   = 8'hA3;
  localparam logic [7:0] OPC_BTCL     = 8'h10;
  localparam logic [7:0] OPC_CALL     = 8'h12;
  localparam logic [7:0] OPC_BSET     = 8'h20;
  localparam logic [7:0] OPC_BCLR     = 8'h30;
  localparam logic [7:0] OPC_CY       = 8'h40;
  localparam logic [7:0] OPC_NCY      = 8'h50;
  localparam logic [7:0] OPC_AZ       = 8'h60;
  localparam logic [7:0] OPC_ANZ      = 8'h70;
  localparam logic [7:0] OPC_JMP_IND  = 8'h73;

  // reset values of the architectural state
  localparam logic [15:0] PC_RST   = 16'h0000;
  localparam logic [7:0]  STK_RST  = 8'h07;
  localparam logic [15:0] DP_RST   = 16'h0000;

  // machine cycle framing: four mclk phases, last one carries the cycle tick
  localparam logic [1:0] PHASE_FIRST = 2'h0;
  localparam logic [1:0] PHASE_LAST  = 2'h3;
  localparam int         MC_PHASES   = 4;

  // bit address field layout, then the byte and word constants of value one
  localparam int         BIT_SFR_POS   = 7;
  localparam logic [3:0] BIT_RAM_BASE  = 4'h2;
  localparam logic [7:0] BYTE_ONE      = 8'h01;
  localparam logic [15:0] WORD_ONE     = 16'h0001;

  // byte lengths of the instructions
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  typedef enum logic [3:0] {
    OP_NONE, OP_INC_DIR, OP_INC_IND, OP_INC_DP, OP_BSET, OP_BCLR, OP_BTCL,
    OP_CY, OP_NCY, OP_AZ, OP_ANZ, OP_JMP_IND, OP_CALL
  } ibe_op_e;

  typedef enum logic {
    ST_IDLE, ST_EXEC
  } ibe_state_e;

  function automatic ibe_op_e ibe_decode(input logic [7:0] opc);
    ibe_op_e op;
    op = OP_NONE;
    unique case (opc)
      OPC_INC_DIR:                op = OP_INC_DIR;
      OPC_INC_IND0, OPC_INC_IND1: op = OP_INC_IND;
      OPC_INC_DP:                 op = OP_INC_DP;
      OPC_BSET:                   op = OP_BSET;
      OPC_BCLR:                   op = OP_BCLR;
      OPC_BTCL:                   op = OP_BTCL;
      OPC_CY:                     op = OP_CY;
      OPC_NCY:                    op = OP_NCY;
      OPC_AZ:                     op = OP_AZ;
      OPC_ANZ:                    op = OP_ANZ;
      OPC_JMP_IND:                op = OP_JMP_IND;
      OPC_CALL:                   op = OP_CALL;
      default:                    op = OP_NONE;
    endcase
    return op;
  endfunction : ibe_decode

  function automatic logic [1:0] ibe_len(input ibe_op_e op);
    logic [1:0] len;
    len = LEN_ONE;
    unique case (op)
      OP_INC_DIR, OP_CY, OP_NCY, OP_AZ, OP_ANZ: len = LEN_TWO;
      OP_BSET, OP_BCLR, OP_BTCL, OP_CALL:       len = LEN_THREE;
      default:                                  len = LEN_ONE;
    endcase
    return len;
  endfunction : ibe_len

  // one for operations that take two machine cycles
  function automatic logic ibe_long(input ibe_op_e op);
    return !(op inside {OP_NONE, OP_INC_DIR, OP_INC_IND});
  endfunction : ibe_long

  // byte that holds a bit: low half maps into the bit-addressable ram, high half onto sfrs
  function automatic logic [7:0] ibe_bit_byte(input logic [7:0] bit_addr);
    return bit_addr[BIT_SFR_POS] ? {bit_addr[7:3], 3'h0} : {BIT_RAM_BASE, bit_addr[6:3]};
  endfunction : ibe_bit_byte

  function automatic logic [15:0] ibe_sext(input logic [7:0] disp);
    return {{8{disp[7]}}, disp};
  endfunction : ibe_sext

endpackage : ibe_pkg

/* File: hdl/ibe_rel_target.sv */
// next program counter: advance by the instruction length, then add the displacement if taken
// assumes pc is the address of the instruction's first byte
`timescale 1ns/1ps
`default_nettype none
module ibe_rel_target (
  input  wire logic [15:0] pc,
  input  wire logic [1:0]  len,
  input  wire logic        taken,
  input  wire logic [7:0]  disp,
  output logic [15:0]      target
);
  logic [15:0] advanced;
  always_comb begin
    advanced = pc + {14'h0000, len};
    // displacement is relative to the advanced pc, sign-extended first
    target   = taken ? advanced + ibe_pkg::ibe_sext(disp) : advanced;
  end
endmodule : ibe_rel_target
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the increment and branch executor: table of branch, indirect jump and data pointer cases, then hand-written cases
// assumes a behavioural data memory; port bytes (80h and up) read inverted on the pins, so a read that skips the latch shows
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [7:0]  opc;
    logic [7:0]  disp;
    logic [7:0]  a;
    logic        cy;
    logic [15:0] pc0;
    logic [15:0] dp0;
    logic [15:0] pc_exp;
    logic [15:0] dp_exp;
  } ibe_row_s;

  // opcode, displacement, accumulator, carry, start pc, start pointer, expected pc, expected pointer
  localparam ibe_row_s ROWS [12] = '{
    '{8'h40, 8'h10, 8'h00, 1'b1, 16'h1000, 16'h0000, 16'h1012, 16'h0000},
    '{8'h40, 8'h10, 8'h00, 1'b0, 16'h1000, 16'h0000, 16'h1002, 16'h0000},
    '{8'h50, 8'hF0, 8'h00, 1'b0, 16'h1000, 16'h0000, 16'h0FF2, 16'h0000},
    '{8'h50, 8'hF0, 8'h00, 1'b1, 16'h1000, 16'h0000, 16'h1002, 16'h0000},
    '{8'h60, 8'h80, 8'h00, 1'b0, 16'h1000, 16'h0000, 16'h0F82, 16'h0000},
    '{8'h60, 8'h80, 8'h01, 1'b0, 16'h1000, 16'h0000, 16'h1002, 16'h0000},
    '{8'h70, 8'h7F, 8'h80, 1'b0, 16'h1000, 16'h0000, 16'h1081, 16'h0000},
    '{8'h70, 8'h7F, 8'h00, 1'b0, 16'h1000, 16'h0000, 16'h1002, 16'h0000},
    '{8'h73, 8'h00, 8'hFF, 1'b1, 16'h1000, 16'h12F1, 16'h13F0, 16'h12F1},
    '{8'hA3, 8'h00, 8'h00, 1'b0, 16'h1000, 16'h00FF, 16'h1001, 16'h0100},
    '{8'hA3, 8'h00, 8'h00, 1'b1, 16'h1000, 16'hFFFF, 16'h1001, 16'h0000},
    '{8'h40, 8'h05, 8'h00, 1'b1, 16'hFFFE, 16'h0000, 16'h0005, 16'h0000}
  };

  logic        mclk;
  logic        resetn;
  logic        exec_valid;
  logic [7:0]  exec_opcode;
  logic [7:0]  exec_byte2;
  logic [7:0]  exec_byte3;
  logic        exec_ready;
  logic        exec_done;
  logic [7:0]  acc;
  logic        carry;
  logic [1:0]  bank_sel;
  logic [7:0]  mem_addr;
  logic [7:0]  mem_rd_data;
  logic [7:0]  mem_wr_data;
  logic        mem_wr_en;
  logic        mem_latch_sel;
  logic        state_wr_en;
  logic [15:0] state_pc;
  logic [7:0]  state_stk;
  logic [15:0] state_dp;
  logic [15:0] pc;
  logic [7:0]  stack_pointer;
  logic [15:0] data_pointer;
  logic [7:0]  mem [256];
  int          err_total;
  int          check_count;

  ibe_exec u_ibe_exec (
    .mclk          (mclk),
    .resetn        (resetn),
    .exec_valid    (exec_valid),
    .exec_opcode   (exec_opcode),
    .exec_byte2    (exec_byte2),
    .exec_byte3    (exec_byte3),
    .exec_ready    (exec_ready),
    .exec_done     (exec_done),
    .acc           (acc),
    .carry         (carry),
    .bank_sel      (bank_sel),
    .mem_addr      (mem_addr),
    .mem_rd_data   (mem_rd_data),
    .mem_wr_data   (mem_wr_data),
    .mem_wr_en     (mem_wr_en),
    .mem_latch_sel (mem_latch_sel),
    .state_wr_en   (state_wr_en),
    .state_pc      (state_pc),
    .state_stk     (state_stk),
    .state_dp      (state_dp),
    .pc            (pc),
    .stack_pointer (stack_pointer),
    .data_pointer  (data_pointer)
  );

  assign mem_rd_data = (mem_addr[7] && !mem_latch_sel) ? ~mem[mem_addr] : mem[mem_addr];

  always @(posedge mclk) begin
    if (mem_wr_en === 1'b1) begin
      mem[mem_addr] <= mem_wr_data;
    end
  end

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bail(input logic stuck);
    if (stuck) begin
      err_total++;
      $display("[FAIL] %0t ns: handshake wait ran out", $time);
      tally_and_finish();
    end
  endtask : bail

  task automatic load_state(input logic [15:0] p, input logic [7:0] s, input logic [15:0] d,
                            input logic [7:0] a, input logic cy);
    @(posedge mclk);
    state_wr_en <= 1'b1;
    state_pc    <= p;
    state_stk   <= s;
    state_dp    <= d;
    acc         <= a;
    carry       <= cy;
    @(posedge mclk);
    state_wr_en <= 1'b0;
    @(negedge mclk);
  endtask : load_state

  // request held from a rising edge until the edge that samples ready high
  task automatic take_op(input logic [7:0] o, input logic [7:0] b2, input logic [7:0] b3);
    int n;
    n = 0;
    @(posedge mclk);
    exec_opcode <= o;
    exec_byte2  <= b2;
    exec_byte3  <= b3;
    exec_valid  <= 1'b1;
    do begin
      @(negedge mclk);
      n++;
    end while (exec_ready !== 1'b1 && n < 40);
    bail(exec_ready !== 1'b1);
    @(posedge mclk);
    exec_valid <= 1'b0;
  endtask : take_op

  // cycles counted from the take edge to the done pulse; state is read after the edge that ends it
  task automatic run_op(input logic [7:0] o, input logic [7:0] b2, input logic [7:0] b3, input int cyc);
    int n;
    n = 0;
    take_op(o, b2, b3);
    do begin
      @(negedge mclk);
      n++;
    end while (exec_done !== 1'b1 && n < 20);
    bail(exec_done !== 1'b1);
    check(16'(n), 16'(cyc));
    @(negedge mclk);
  endtask : run_op

  initial begin
    err_total   = 0;
    check_count = 0;
    resetn      = 1'b0;
    exec_valid  = 1'b0;
    exec_opcode = 8'h00;
    exec_byte2  = 8'h00;
    exec_byte3  = 8'h00;
    acc         = 8'h00;
    carry       = 1'b0;
    bank_sel    = 2'h0;
    state_wr_en = 1'b0;
    state_pc    = 16'h0000;
    state_stk   = 8'h00;
    state_dp    = 16'h0000;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h00;
    end
    @(posedge mclk);
    @(negedge mclk);
    check(pc, ibe_pkg::PC_RST);
    check({8'h00, stack_pointer}, {8'h00, ibe_pkg::STK_RST});
    check(data_pointer, ibe_pkg::DP_RST);
    check({14'h0000, exec_ready, exec_done}, 16'h0000);
    @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      load_state(ROWS[i].pc0, 8'h07, ROWS[i].dp0, ROWS[i].a, ROWS[i].cy);
      run_op(ROWS[i].opc, ROWS[i].disp, 8'h00, 8);
      check(pc, ROWS[i].pc_exp);
      check(data_pointer, ROWS[i].dp_exp);
      check({8'h00, stack_pointer}, 16'h0007);
    end
    load_state(16'h0200, 8'h07, 16'h0000, 8'h00, 1'b0);
    mem[8'h30] = 8'hFF;
    mem[8'h90] = 8'h5A;
    mem[8'h11] = 8'h40;
    mem[8'h40] = 8'h7F;
    mem[8'h10] = 8'h41;
    mem[8'h41] = 8'h10;
    mem[8'h25] = 8'h04;
    run_op(8'h05, 8'h30, 8'h00, 4);
    check({mem[8'h30], pc[7:0]}, 16'h0002);
    run_op(8'h05, 8'h90, 8'h00, 4);
    check({8'h00, mem[8'h90]}, 16'h005B);
    @(posedge mclk);
    bank_sel <= 2'h2;
    run_op(8'h07, 8'h00, 8'h00, 4);
    check({mem[8'h40], mem[8'h11]}, 16'h8040);
    run_op(8'h06, 8'h00, 8'h00, 4);
    check({mem[8'h41], mem[8'h10]}, 16'h1141);
    check(pc, 16'h0206);
    run_op(8'h20, 8'h2A, 8'hFC, 8);
    check(pc, 16'h0205);
    run_op(8'h20, 8'h29, 8'hFC, 8);
    check({mem[8'h25], pc[7:0]}, 16'h0408);
    run_op(8'h30, 8'h29, 8'h10, 8);
    check(pc, 16'h021B);
    run_op(8'h30, 8'h2A, 8'h10, 8);
    check({mem[8'h25], pc[7:0]}, 16'h041E);
    run_op(8'h10, 8'h2A, 8'h02, 8);
    check({mem[8'h25], pc[7:0]}, 16'h0023);
    mem[8'h25] = 8'hFB;
    run_op(8'h10, 8'h2A, 8'h02, 8);
    check({mem[8'h25], pc[7:0]}, 16'hFB26);
    mem[8'h90] = 8'h04;
    run_op(8'h10, 8'h92, 8'h80, 8);
    check(pc, 16'h01A9);
    check({8'h00, mem[8'h90]}, 16'h0000);
    load_state(16'h0123, 8'h07, 16'h0000, 8'h00, 1'b0);
    run_op(8'h12, 8'h12, 8'h34, 8);
    check({8'h00, stack_pointer}, 16'h0009);
    check({mem[8'h09], mem[8'h08]}, 16'h0126);
    check(pc, 16'h1234);
    // reset lands in the middle of a call; state must fall back to its reset values
    take_op(8'h12, 8'h56, 8'h78);
    repeat (3) @(posedge mclk);
    resetn <= 1'b0;
    @(negedge mclk);
    check(pc, ibe_pkg::PC_RST);
    check({8'h00, stack_pointer}, {8'h00, ibe_pkg::STK_RST});
    @(posedge mclk);
    resetn <= 1'b1;
    run_op(8'hA3, 8'h00, 8'h00, 8);
    check(data_pointer, 16'h0001);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
